// >>> design/drf_regs.svh
// constants for the dual-block data register file: map, indices, lanes
// assumes inclusion by its bare name from the design files
`ifndef DRF_REGS_SVH
`define DRF_REGS_SVH

// geometry
`define DRF_NREGS 32
`define DRF_NSLOT 4
`define DRF_NBLK 2

// apb map: block x words, then block y words
`define DRF_X_BASE 12'h000
`define DRF_Y_BASE 12'h080
`define DRF_MAP_END 12'h100
`define DRF_ADDR_BLK_BIT 7
`define DRF_ADDR_IDX_HI 6
`define DRF_ADDR_IDX_LO 2

// alignment of register groups
`define DRF_PAIR_MASK 5'h1e
`define DRF_QUAD_MASK 5'h1c
`define DRF_SPAN_SINGLE 32'h0000_0001
`define DRF_SPAN_DOUBLE 32'h0000_0003
`define DRF_SPAN_QUAD 32'h0000_000f

// lane widths and operand widths in bytes
`define DRF_LB_BYTE 5'h01
`define DRF_LB_SHORT 5'h02
`define DRF_LB_NORMAL 5'h04
`define DRF_LB_LONG 5'h08
`define DRF_TB_SINGLE 5'h04
`define DRF_TB_DOUBLE 5'h08
`define DRF_TB_QUAD 5'h10
`define DRF_LANE_ONE 5'h01

// reset values
`define DRF_WORD_ZERO 32'h0000_0000
`define DRF_QUAD_ZERO 128'h0

`endif

// >>> design/drf_pkg.sv
// types shared by the dual-block data register file and its parts
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package drf_pkg;

  typedef logic [31:0] drf_word_type;
  typedef logic [31:0][31:0] drf_array_type;
  typedef logic [4:0] drf_idx_type;
  typedef logic [127:0] drf_quad_type;

  // block select carried by each instruction slot
  typedef enum logic [1:0] {
    BLK_NOPFX = 2'b00,
    BLK_X = 2'b01,
    BLK_Y = 2'b10,
    BLK_BOTH = 2'b11
  } drf_blk_type;

  typedef enum logic [1:0] {
    W_SINGLE = 2'b00,
    W_DOUBLE = 2'b01,
    W_QUAD = 2'b10
  } drf_width_type;

  typedef enum logic [1:0] {
    SZ_NORMAL = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_SHORT = 2'b10,
    SZ_LONG = 2'b11
  } drf_size_type;

  typedef enum logic [1:0] {
    U_ALU = 2'b00,
    U_MUL = 2'b01,
    U_SHIFT = 2'b10,
    U_CLU = 2'b11
  } drf_unit_type;

  typedef enum logic [1:0] {
    F_FIXED = 2'b00,
    F_FLOAT32 = 2'b01,
    F_FLOAT40 = 2'b10
  } drf_fmt_type;

  // one instruction slot asking for operands
  typedef struct packed {
    logic valid;
    drf_blk_type both_blocks_select;
    drf_width_type width;
    drf_size_type size;
    logic flt;
    drf_unit_type unit;
    logic int_dest;
    drf_idx_type dst;
    drf_idx_type src_m;
    drf_idx_type src_n;
  } drf_slot_req_type;

  // operands handed to the compute units
  typedef struct packed {
    logic valid;
    logic run_x;
    logic run_y;
    drf_fmt_type fmt;
    logic [15:0] lane_end;
    drf_quad_type m_x;
    drf_quad_type n_x;
    drf_quad_type m_y;
    drf_quad_type n_y;
  } drf_operand_type;

  // a result coming back from a compute unit
  typedef struct packed {
    logic valid;
    drf_blk_type both_blocks_select;
    drf_width_type width;
    drf_idx_type dst;
    drf_quad_type data_x;
    drf_quad_type data_y;
  } drf_result_type;

  // a quad-word beat of a load from memory
  typedef struct packed {
    logic valid;
    logic first;
    drf_blk_type both_blocks_select;
    drf_width_type width;
    drf_idx_type dst;
    logic [1:0] woff;
    drf_quad_type data;
  } drf_load_type;

  // an aligned register write
  typedef struct packed {
    logic valid;
    drf_blk_type both_blocks_select;
    drf_width_type width;
    drf_idx_type dst;
    drf_quad_type data;
  } drf_wr_type;

endpackage : drf_pkg

`default_nettype wire

// >>> design/drf_bank.sv
// one compute block's data register file: thirty-two 32-bit words
// assumes the parent merges all write sources into one word-wise port
`default_nettype none
`include "drf_regs.svh"

module drf_bank (
  // clock
  input wire logic pclk,
  // merged word writes
  input wire logic [`DRF_NREGS-1:0] we,
  input wire drf_pkg::drf_array_type wdata,
  // every word, straight from the flip-flops
  output drf_pkg::drf_array_type rdata
);

  drf_pkg::drf_array_type mem_ff;

  // storage holds no reset value: contents are undefined until written
  always_ff @(posedge pclk) begin
    for (int i = 0; i < `DRF_NREGS; i++) begin
      if (we[i]) begin
        mem_ff[i] <= wdata[i];
      end
    end
  end

  assign rdata = mem_ff;

endmodule : drf_bank

`default_nettype wire

// >>> design/drf_align_buf.sv
// load alignment buffer: turns misaligned quad-word beats into aligned data
// assumes a misaligned stream opens with a beat flagged first
`default_nettype none
`include "drf_regs.svh"

module drf_align_buf (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // beats from memory
  input wire drf_pkg::drf_load_type load_in,
  // aligned write toward the register files
  output drf_pkg::drf_wr_type wr_out
);

  drf_pkg::drf_quad_type prev_ff;
  drf_pkg::drf_wr_type wr_ff;
  drf_pkg::drf_wr_type nxt_wr;
  drf_pkg::drf_quad_type nxt_prev;

  // pick the wanted four words out of two adjacent beats
  function automatic drf_pkg::drf_quad_type shift_quad(
    input drf_pkg::drf_quad_type cur,
    input drf_pkg::drf_quad_type prev,
    input logic [1:0] woff
  );
    drf_pkg::drf_quad_type v;
    begin
      case (woff)
        2'h1: v = {cur[31:0], prev[127:32]};
        2'h2: v = {cur[63:0], prev[127:64]};
        2'h3: v = {cur[95:0], prev[127:96]};
        default: v = cur;
      endcase
      return v;
    end
  endfunction : shift_quad

  // aligned beats pass, a first misaligned beat only primes the buffer
  always_comb begin
    nxt_prev = prev_ff;
    nxt_wr.valid = 1'b0;
    nxt_wr.both_blocks_select = load_in.both_blocks_select;
    nxt_wr.width = load_in.width;
    nxt_wr.dst = load_in.dst;
    nxt_wr.data = shift_quad(load_in.data, prev_ff, load_in.woff);
    if (load_in.valid) begin
      nxt_prev = load_in.data;
      nxt_wr.valid = !(load_in.first && load_in.woff != 2'h0);
    end
  end

  // older entry and presented entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= `DRF_QUAD_ZERO;
      wr_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
      wr_ff <= nxt_wr;
    end
  end

  assign wr_out = wr_ff;

endmodule : drf_align_buf

`default_nettype wire

// >>> design/drf_top.sv
// dual-block data register file with interlock, operand ports and apb
// assumes compute units return results through result_in and that each
// line names any register as destination at most once
`default_nettype none
`include "drf_regs.svh"

module drf_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction line issue
  input wire drf_pkg::drf_slot_req_type [`DRF_NSLOT-1:0] line_req,
  input wire logic line_valid,
  output logic line_ready,
  output logic line_misalign,
  // operands to the compute units
  output drf_pkg::drf_operand_type [`DRF_NSLOT-1:0] operand_out,
  // results back from the compute units
  input wire drf_pkg::drf_result_type [`DRF_NSLOT-1:0] result_in,
  // memory loads
  input wire drf_pkg::drf_load_type load_in
);

  typedef enum logic {
    APB_ARM = 1'b0,
    APB_ACK = 1'b1
  } drf_apb_state_type;

  drf_apb_state_type apb_state_ff;
  drf_apb_state_type nxt_apb_state;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic misalign_ff;
  logic nxt_misalign;
  logic [`DRF_NBLK-1:0][`DRF_NREGS-1:0] busy_ff;
  logic [`DRF_NBLK-1:0][`DRF_NREGS-1:0] nxt_busy;
  logic [`DRF_NBLK-1:0][`DRF_NREGS-1:0] use_mask;
  logic [`DRF_NBLK-1:0][`DRF_NREGS-1:0] set_mask;
  logic [`DRF_NBLK-1:0][`DRF_NREGS-1:0] clr_mask;
  logic [`DRF_NBLK-1:0][`DRF_NREGS-1:0] we;
  drf_pkg::drf_array_type wd [`DRF_NBLK];
  drf_pkg::drf_array_type rd [`DRF_NBLK];
  drf_pkg::drf_operand_type [`DRF_NSLOT-1:0] op_ff;
  drf_pkg::drf_operand_type [`DRF_NSLOT-1:0] nxt_op;
  drf_pkg::drf_wr_type load_wr;
  logic hazard;
  logic issue;
  logic any_misalign;

  // snap an index down to the start of its register group
  function automatic drf_pkg::drf_idx_type align_idx(
    input drf_pkg::drf_idx_type i,
    input drf_pkg::drf_width_type w
  );
    begin
      case (w)
        drf_pkg::W_DOUBLE: return i & `DRF_PAIR_MASK;
        drf_pkg::W_QUAD: return i & `DRF_QUAD_MASK;
        default: return i;
      endcase
    end
  endfunction : align_idx

  // words touched by an operand of the given width
  function automatic logic [`DRF_NREGS-1:0] range_mask(
    input drf_pkg::drf_idx_type i,
    input drf_pkg::drf_width_type w
  );
    logic [`DRF_NREGS-1:0] span;
    begin
      case (w)
        drf_pkg::W_DOUBLE: span = `DRF_SPAN_DOUBLE;
        drf_pkg::W_QUAD: span = `DRF_SPAN_QUAD;
        default: span = `DRF_SPAN_SINGLE;
      endcase
      return span << align_idx(i, w);
    end
  endfunction : range_mask

  // whether a slot or write acts in block b
  function automatic logic runs_in(
    input drf_pkg::drf_blk_type sel,
    input int b
  );
    begin
      if (b == 0) begin
        return sel != drf_pkg::BLK_Y;
      end
      return sel != drf_pkg::BLK_X;
    end
  endfunction : runs_in

  // gather an operand of one, two or four words, upper words zero
  function automatic drf_pkg::drf_quad_type read_op(
    input drf_pkg::drf_array_type a,
    input drf_pkg::drf_idx_type i,
    input drf_pkg::drf_width_type w
  );
    drf_pkg::drf_quad_type v;
    drf_pkg::drf_idx_type b;
    begin
      v = `DRF_QUAD_ZERO;
      b = align_idx(i, w);
      case (w)
        drf_pkg::W_DOUBLE: v[63:0] = {a[b | 5'h01], a[b]};
        drf_pkg::W_QUAD: v = {a[b | 5'h03], a[b | 5'h02],
                              a[b | 5'h01], a[b]};
        default: v[31:0] = a[b];
      endcase
      return v;
    end
  endfunction : read_op

  // word of a group write that lands on register i
  function automatic drf_pkg::drf_word_type pick_word(
    input drf_pkg::drf_quad_type d,
    input drf_pkg::drf_idx_type base,
    input drf_pkg::drf_idx_type i
  );
    drf_pkg::drf_idx_type off;
    begin
      off = i - base;
      return d[32 * off[1:0] +: 32];
    end
  endfunction : pick_word

  // mark the last byte of each lane so units break carries there
  function automatic logic [15:0] lane_ends(
    input drf_pkg::drf_slot_req_type r
  );
    logic [4:0] lb;
    logic [4:0] tb;
    logic [15:0] m;
    begin
      m = '0;
      case (r.width)
        drf_pkg::W_DOUBLE: tb = `DRF_TB_DOUBLE;
        drf_pkg::W_QUAD: tb = `DRF_TB_QUAD;
        default: tb = `DRF_TB_SINGLE;
      endcase
      if (r.flt) begin
        lb = (r.width == drf_pkg::W_SINGLE) ? `DRF_LB_NORMAL : `DRF_LB_LONG;
      end else begin
        case (r.size)
          drf_pkg::SZ_BYTE: lb = (r.unit == drf_pkg::U_MUL) ?
                                 `DRF_LB_SHORT : `DRF_LB_BYTE;
          drf_pkg::SZ_SHORT: lb = `DRF_LB_SHORT;
          drf_pkg::SZ_LONG: lb = (r.width == drf_pkg::W_SINGLE ||
                                  r.unit == drf_pkg::U_MUL) ?
                                 `DRF_LB_NORMAL : `DRF_LB_LONG;
          default: lb = `DRF_LB_NORMAL;
        endcase
      end
      for (int k = 0; k < 16; k++) begin
        if (5'(k) < tb && (5'(k + 1) & (lb - `DRF_LANE_ONE)) == 5'h00) begin
          m[k] = 1'b1;
        end
      end
      return m;
    end
  endfunction : lane_ends

  // format of the data held by the operand
  function automatic drf_pkg::drf_fmt_type fmt_of(
    input drf_pkg::drf_slot_req_type r
  );
    begin
      if (!r.flt) begin
        return drf_pkg::F_FIXED;
      end
      return (r.width == drf_pkg::W_SINGLE) ?
             drf_pkg::F_FLOAT32 : drf_pkg::F_FLOAT40;
    end
  endfunction : fmt_of

  // apb decode
  wire apb_access = psel && penable;
  wire apb_mapped = paddr < `DRF_MAP_END;
  wire apb_blk = paddr[`DRF_ADDR_BLK_BIT];
  wire [4:0] apb_idx = paddr[`DRF_ADDR_IDX_HI:`DRF_ADDR_IDX_LO];
  wire apb_busy = busy_ff[apb_blk][apb_idx];
  wire apb_wr = apb_access && pwrite && apb_mapped &&
                apb_state_ff == APB_ACK;

  // per-slot demand on each file and misalignment check
  always_comb begin
    use_mask = '0;
    set_mask = '0;
    clr_mask = '0;
    any_misalign = 1'b0;
    for (int s = 0; s < `DRF_NSLOT; s++) begin
      for (int b = 0; b < `DRF_NBLK; b++) begin
        if (line_req[s].valid && runs_in(line_req[s].both_blocks_select, b))
        begin
          use_mask[b] = use_mask[b] |
                        range_mask(line_req[s].src_m, line_req[s].width) |
                        range_mask(line_req[s].src_n, line_req[s].width);
          if (!line_req[s].int_dest) begin
            set_mask[b] = set_mask[b] |
                          range_mask(line_req[s].dst, line_req[s].width);
          end
        end
        if (result_in[s].valid &&
            runs_in(result_in[s].both_blocks_select, b)) begin
          clr_mask[b] = clr_mask[b] |
                        range_mask(result_in[s].dst, result_in[s].width);
        end
      end
      if (line_req[s].valid &&
          (align_idx(line_req[s].dst, line_req[s].width) != line_req[s].dst ||
           align_idx(line_req[s].src_m, line_req[s].width) !=
             line_req[s].src_m ||
           align_idx(line_req[s].src_n, line_req[s].width) !=
             line_req[s].src_n)) begin
        any_misalign = 1'b1;
      end
    end
  end

  assign hazard = |(busy_ff & (use_mask | set_mask));
  assign issue = line_valid && !hazard;
  assign line_ready = !hazard;
  assign nxt_misalign = issue && any_misalign;

  // scoreboard, a new reservation wins over a clear
  always_comb begin
    for (int b = 0; b < `DRF_NBLK; b++) begin
      nxt_busy[b] = (busy_ff[b] & ~clr_mask[b]) |
                    (issue ? set_mask[b] : '0);
    end
  end

  // operands gathered fresh per slot, per issue
  always_comb begin
    for (int s = 0; s < `DRF_NSLOT; s++) begin
      nxt_op[s].valid = issue && line_req[s].valid;
      nxt_op[s].run_x = runs_in(line_req[s].both_blocks_select, 0);
      nxt_op[s].run_y = runs_in(line_req[s].both_blocks_select, 1);
      nxt_op[s].fmt = fmt_of(line_req[s]);
      nxt_op[s].lane_end = lane_ends(line_req[s]);
      nxt_op[s].m_x = read_op(rd[0], line_req[s].src_m, line_req[s].width);
      nxt_op[s].n_x = read_op(rd[0], line_req[s].src_n, line_req[s].width);
      nxt_op[s].m_y = read_op(rd[1], line_req[s].src_m, line_req[s].width);
      nxt_op[s].n_y = read_op(rd[1], line_req[s].src_n, line_req[s].width);
    end
  end

  // write merge: results over load over apb, word by word
  always_comb begin
    for (int b = 0; b < `DRF_NBLK; b++) begin
      for (int i = 0; i < `DRF_NREGS; i++) begin
        we[b][i] = 1'b0;
        wd[b][i] = pwdata;
        if (apb_wr && int'(apb_blk) == b && apb_idx == 5'(i)) begin
          we[b][i] = 1'b1;
        end
        if (load_wr.valid && runs_in(load_wr.both_blocks_select, b) &&
            |(range_mask(load_wr.dst, load_wr.width) &
              (`DRF_SPAN_SINGLE << i))) begin
          we[b][i] = 1'b1;
          wd[b][i] = pick_word(load_wr.data,
                               align_idx(load_wr.dst, load_wr.width), 5'(i));
        end
        for (int s = 0; s < `DRF_NSLOT; s++) begin
          if (result_in[s].valid &&
              runs_in(result_in[s].both_blocks_select, b) &&
              |(range_mask(result_in[s].dst, result_in[s].width) &
                (`DRF_SPAN_SINGLE << i))) begin
            we[b][i] = 1'b1;
            wd[b][i] = pick_word((b == 0) ? result_in[s].data_x :
                                 result_in[s].data_y,
                                 align_idx(result_in[s].dst,
                                           result_in[s].width), 5'(i));
          end
        end
      end
    end
  end

  // apb: one wait cycle, more while a mapped word is busy, then pready with data from flip-flops
  always_comb begin
    nxt_apb_state = APB_ARM;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    case (apb_state_ff)
      APB_ARM: begin
        if (apb_access && (!apb_mapped || !apb_busy)) begin
          nxt_apb_state = APB_ACK;
          nxt_pslverr = !apb_mapped;
          nxt_prdata = (apb_mapped && !pwrite) ? rd[apb_blk][apb_idx] :
                       `DRF_WORD_ZERO;
        end
      end
      APB_ACK: begin
        nxt_apb_state = APB_ARM;
      end
      default: begin
        nxt_apb_state = APB_ARM;
      end
    endcase
  end

  // control state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_ff <= APB_ARM;
      prdata_ff <= `DRF_WORD_ZERO;
      pslverr_ff <= 1'b0;
      busy_ff <= '0;
      misalign_ff <= 1'b0;
      op_ff <= '0;
    end else begin
      apb_state_ff <= nxt_apb_state;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      busy_ff <= nxt_busy;
      misalign_ff <= nxt_misalign;
      op_ff <= nxt_op;
    end
  end

  for (genvar g = 0; g < `DRF_NBLK; g++) begin : g_bank
    drf_bank u_bank (
      .pclk(pclk),
      .we(we[g]),
      .wdata(wd[g]),
      .rdata(rd[g])
    );
  end

  drf_align_buf u_align (
    .pclk(pclk),
    .presetn(presetn),
    .load_in(load_in),
    .wr_out(load_wr)
  );

  // outputs
  assign prdata = prdata_ff;
  assign pready = apb_state_ff == APB_ACK;
  assign pslverr = pslverr_ff;
  assign line_misalign = misalign_ff;
  assign operand_out = op_ff;

endmodule : drf_top

`default_nettype wire

// >>> bench/drf_top_checker.sv
// checker of apb answers, operand issue, block select and stalls
// assumes binding onto drf_top and a single pclk domain
`default_nettype none
`include "drf_regs.svh"

module drf_top_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // issue side
  input wire drf_pkg::drf_slot_req_type [`DRF_NSLOT-1:0] line_req,
  input wire logic line_valid,
  input wire logic line_ready,
  input wire logic line_misalign,
  input wire drf_pkg::drf_operand_type [`DRF_NSLOT-1:0] operand_out,
  input wire drf_pkg::drf_result_type [`DRF_NSLOT-1:0] result_in
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // slot zero taken, then a single x write left pending
  sequence s_take;
    line_valid && line_ready && line_req[0].valid;
  endsequence
  sequence s_pend;
    s_take ##0 (line_req[0].both_blocks_select == drf_pkg::BLK_X &&
    line_req[0].width == drf_pkg::W_SINGLE && !line_req[0].int_dest)
    ##1 !result_in[0].valid;
  endsequence

  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_UNMAPPED: assert property (psel && penable && !pready &&
    paddr >= 12'h100 |=> pready && pslverr) else $error("no error answer");
  AST_OPND_LAT: assert property (s_take |=> operand_out[0].valid)
    else $error("operands late");
  AST_OPND_IDLE: assert property (
    !line_valid |=> !operand_out[0].valid) else $error("stray operands");
  AST_SEL_X: assert property (
    s_take ##0 (line_req[0].both_blocks_select == drf_pkg::BLK_X)
    |=> operand_out[0].run_x && !operand_out[0].run_y)
    else $error("block x select wrong");
  AST_SEL_BOTH: assert property (
    s_take ##0 (line_req[0].both_blocks_select[0] ==
    line_req[0].both_blocks_select[1])
    |=> operand_out[0].run_x && operand_out[0].run_y)
    else $error("both block select wrong");
  AST_BUSY_STALL: assert property (
    s_pend ##1 (line_valid && line_req[0].valid && !result_in[0].valid &&
    line_req[0].both_blocks_select == drf_pkg::BLK_X &&
    line_req[0].width == drf_pkg::W_SINGLE &&
    line_req[0].src_m == $past(line_req[0].dst, 2)) |-> !line_ready)
    else $error("read of pending word not stalled");
  AST_MISALIGN: assert property (
    s_take ##0 (line_req[0].width == drf_pkg::W_DOUBLE &&
    line_req[0].src_m[0]) |=> line_misalign) else $error("odd pair base");
endmodule : drf_top_checker

bind drf_top drf_top_checker chk (.pclk, .presetn, .psel, .penable, .paddr,
  .pready, .pslverr, .line_req, .line_valid, .line_ready, .line_misalign,
  .operand_out, .result_in);
`default_nettype wire

// >>> bench/drf_unit_model.sv
// compute unit stand-in for slot zero: xor of operands, prompt or slow
// assumes one line in flight at a time
`default_nettype none

module drf_unit_model (
  // clock
  input wire logic pclk,
  // issue and operands
  input wire drf_pkg::drf_slot_req_type req,
  input wire logic take,
  input wire drf_pkg::drf_operand_type opnd,
  input wire logic slow,
  // result back to the file
  output drf_pkg::drf_result_type res
);
  timeunit 1ns;
  timeprecision 1ns;
  drf_pkg::drf_slot_req_type held;
  drf_pkg::drf_operand_type od;
  int cnt = -1;

  initial res = '0;
  always @(posedge pclk) begin
    res.valid <= 1'b0;
    res.data_x <= ~res.data_x;
    if (take) held <= req;
    if (opnd.valid) begin
      od <= opnd;
      cnt <= slow ? 6 : 0;
    end else if (cnt > 0) cnt <= cnt - 1;
    else if (cnt == 0) begin
      res <= '{1'b1, held.both_blocks_select, held.width, held.dst,
        od.m_x ^ od.n_x, od.m_y ^ od.n_y};
      cnt <= -1;
    end
  end
endmodule : drf_unit_model
`default_nettype wire

// >>> bench/dual_block_data_register_file_bench.sv
// self-checking bench: apb fill and readback, operand issue, interlock
// assumes design, checker and unit model compiled ahead of it
`default_nettype none
`include "drf_regs.svh"

module dual_block_data_register_file_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic line_valid, line_ready, line_misalign, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, rd, mdl [64];
  logic [127:0] ux, uy;
  drf_pkg::drf_slot_req_type [`DRF_NSLOT-1:0] line_req;
  drf_pkg::drf_operand_type [`DRF_NSLOT-1:0] operand_out;
  wire drf_pkg::drf_result_type [`DRF_NSLOT-1:0] result_in;
  drf_pkg::drf_load_type load_in;
  drf_pkg::drf_slot_req_type pq [$];
  drf_pkg::drf_slot_req_type rq;
  int miscompares, total_checks, i, j, k, c2, k2, ds, ms, ns;

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  drf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .line_req, .line_valid, .line_ready,
    .line_misalign, .operand_out, .result_in, .load_in);
  drf_unit_model unit (.pclk, .req(line_req[0]), .slow, .res(result_in[0]),
    .take(line_valid && line_ready), .opnd(operand_out[0]));
  assign result_in[3:1] = '0;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [127:0] grab(input int b, i, c);
    int k;
    grab = '0;
    for (k = 0; k < c; k++) grab[32*k +: 32] = mdl[32*b + i + k];
    return grab;
  endfunction : grab

  task automatic chk(input string n, input logic [127:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    if (n >= 200) miscompares++;
    if (n >= 200) complete_run();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // issue one slot, check its operands, optionally read the result back
  task automatic run(input int b, w, z, f, u, d, m, n, wt);
    int c, x, t;
    logic [15:0] le;
    c = 1 << w;
    line_req[0] <= '{1'b1, drf_pkg::drf_blk_type'(b),
      drf_pkg::drf_width_type'(w), drf_pkg::drf_size_type'(z), f[0],
      drf_pkg::drf_unit_type'(u), 1'b0, d[4:0], m[4:0], n[4:0]};
    line_valid <= 1'b1;
    x = 0;
    do begin
      @(posedge pclk);
      x++;
    end while (line_ready !== 1'b1 && x < 200);
    if (x >= 200) miscompares++;
    if (x >= 200) complete_run();
    pq.push_back(line_req[0]);
    line_valid <= 1'b0;
    @(posedge pclk);
    chk("valid", operand_out[0].valid, 1'b1);
    chk("misalign", line_misalign, ((d | m | n) & (c - 1)) != 0);
    chk("run", {operand_out[0].run_x, operand_out[0].run_y},
      {b != 2, b != 1});
    chk("fmt", operand_out[0].fmt, f ? (w ? 2 : 1) : 0);
    t = z == 1 ? 1 : z == 2 ? 2 : z == 3 ? 8 : 4;
    if (u == 1) t = z == 1 ? 2 : z == 3 ? 4 : t;
    if (f) t = w ? 8 : 4;
    le = '0;
    for (x = 0; x < 4 * c; x++) le[x] = x % t == t - 1;
    chk("lanes", operand_out[0].lane_end, le);
    m = m & ~(c - 1);
    n = n & ~(c - 1);
    d = d & ~(c - 1);
    if (b != 2) chk("m_x", operand_out[0].m_x, grab(0, m, c));
    if (b != 2) chk("n_x", operand_out[0].n_x, grab(0, n, c));
    if (b != 1) chk("m_y", operand_out[0].m_y, grab(1, m, c));
    if (b != 1) chk("n_y", operand_out[0].n_y, grab(1, n, c));
    x = b == 2 ? 32 + d : d;
    if (wt) apb(1'b0, 12'(4 * x), 0);
    if (wt) chk("result", rd, mdl[x]);
  endtask : run

  // model takes each result as the xor of its aligned sources
  always @(posedge pclk) begin
    if (result_in[0].valid === 1'b1 && pq.size() > 0) begin
      rq = pq.pop_front();
      c2 = 1 << rq.width;
      ms = rq.src_m & ~(c2 - 1);
      ns = rq.src_n & ~(c2 - 1);
      ds = rq.dst & ~(c2 - 1);
      ux = grab(0, ms, c2) ^ grab(0, ns, c2);
      uy = grab(1, ms, c2) ^ grab(1, ns, c2);
      for (k2 = 0; k2 < c2; k2++) begin
        if (rq.both_blocks_select != 2) mdl[ds + k2] = ux[32*k2 +: 32];
        if (rq.both_blocks_select != 1) mdl[32 + ds + k2] = uy[32*k2 +: 32];
      end
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    line_valid = 1'b0;
    line_req = '0;
    load_in = '0;
    slow = 1'b0;
    rnd = 32'h0000_003b;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // fill both files from the lfsr, read every word back
    for (i = 0; i < 64; i++) begin
      rnd = lfsr(rnd);
      mdl[i] = rnd;
      apb(1'b1, 12'(4 * i), rnd);
    end
    for (i = 0; i < 64; i++) begin
      apb(1'b0, 12'(4 * i), 0);
      chk("word", rd, mdl[i]);
      chk("err", er, 1'b0);
    end
    // misaligned x quad load: first beat primes, second beat lands it
    ux = {lfsr(rnd), rnd, lfsr(~rnd), ~rnd};
    uy = ~ux;
    load_in <= '{1'b1, 1'b1, drf_pkg::BLK_X, drf_pkg::W_QUAD, 5'h18, 2'h1,
      ux};
    @(posedge pclk);
    load_in.first <= 1'b0;
    load_in.data <= uy;
    @(posedge pclk);
    load_in <= '0;
    ux = {uy[31:0], ux[127:32]};
    for (i = 0; i < 4; i++) mdl[24 + i] = ux[32 * i +: 32];
    for (i = 24; i < 28; i++) begin
      apb(1'b0, 12'(4 * i), 0);
      chk("load", rd, mdl[i]);
    end
    // unmapped write then read
    apb(1'b1, 12'h100, -1);
    chk("err", er, 1'b1);
    apb(1'b0, 12'hffc, 0);
    chk("err", er, 1'b1);
    chk("word", rd, 32'h0);
    // every block select, prompt and slow units
    for (i = 0; i < 4; i++) begin
      slow <= i[0];
      run(i, 0, 0, 0, 0, 8 + i, i, i + 1, 1);
      apb(1'b0, 12'(4 * (40 + i)), 0);
      chk("word y", rd, mdl[40 + i]);
    end
    // widths, sizes, float, alu and multiplier
    for (i = 0; i < 3; i++)
      for (j = 0; j < 5; j++)
        for (k = 0; k < 2; k++)
          if (!(i == 0 && j == 3)) run(3, i, j % 4, j == 4, k, 16, 20, 24, 1);
    // misaligned pair and quad indices forced down
    run(1, 1, 0, 0, 0, 2, 7, 12, 1);
    run(1, 2, 0, 0, 0, 4, 9, 13, 1);
    // read of a pending destination stalls until the result lands
    slow <= 1'b1;
    run(1, 0, 0, 0, 0, 5, 1, 2, 0);
    run(1, 0, 0, 0, 0, 6, 5, 3, 1);
    complete_run();
  end
endmodule : dual_block_data_register_file_bench
`default_nettype wire
